// File: rtl/alc_top.sv
// list-based converter control: error flags, soft reset, lists, sequencer
//
// Overview of operation
// [R1] severe error flags halt all conversion
// [R2] soft reset clears severe flags, resumes
// [R3] restart and load flags never halt
// [R4] restart/load flags clear by one, reset
// [R5] disabled converter holds all flags clear
// [R6] writing zero ignored; one never sets
// [R7] severe flags ignore software writes
// [R8] bit 7 illegal access on fetch/store
// [R9] bit 6 reserved bits or resolution
// [R10] bit 5 missing end of list
// [R11] two-cycle pump before every sample
// [R12] resolution selectable 8, 10, 12 bits
// [R13] binary search output code
// [R14] saturated code outside reference span
// [R15] both lists double buffered, own mode
// [R16] command double buffered, readable
// [R17] halted: ignore triggers, no memory access
module alc_top
  import alc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr, // register byte address
  input wire logic [31:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [31:0] reg_rdata, // read data, cycle after strobe
  input wire logic trig_in, // conversion trigger, same clock
  input wire logic [11:0] sample_in, // held analog sample, scaled
  input wire logic below_low_in, // comparator: under low reference
  input wire logic above_high_in, // comparator: over high reference
  output logic mem_rd, // memory read request, one cycle
  output logic mem_wr, // memory write request, one cycle
  output logic [31:0] mem_addr, // memory address
  output logic [31:0] mem_wdata, // result to store
  input wire logic [31:0] mem_rdata, // command word, same cycle as mem_rd
  input wire logic mem_err, // access error, same cycle as mem_wr
  output logic pump_on, // pump phase active
  output logic sample_on, // sample phase active
  output logic irq // level interrupt
);
  // ======================================================================
  // registers
  logic en_reg; // converter enable
  logic cbm_reg; // command_list_buffer_mode
  logic rbm_reg; // result_list_buffer_mode
  logic [7:0] eif_reg; // converter_error_flags
  logic [7:0] eie_reg; // interrupt mask
  logic [31:0] csl_base_reg [2]; // command list bases
  logic [31:0] rvl_base_reg [2]; // result list bases
  logic csl_sel_reg; // active command buffer
  logic rvl_sel_reg; // active result buffer
  logic [31:0] cmd_reg; // active command
  logic [31:0] cmd_next_reg; // fetched command waiting
  logic [11:0] res_reg; // last result
  logic [3:0] cidx_reg; // command index in list
  logic [3:0] ridx_reg; // result index in list
  logic [1:0] pump_cnt_reg; // pump cycles left
  logic fetch_wait_reg; // command read in flight
  logic store_wait_reg; // result write in flight
  logic trig_pend_reg; // trigger waiting to run
  alc_state_t state_reg;
  logic sar_start_q; // sample phase done, start search
  // ======================================================================
  // decode
  logic wr_ctrl, wr_eif, wr_eie, srst, ldok_req, rstar_req;
  logic severe, sar_done, sar_start;
  logic [11:0] sar_code;
  logic [7:0] ev_set; // hardware error events this cycle
  logic cmd_bad, addr_bad;
  logic [31:0] cur_addr;
  assign wr_ctrl = reg_wr && (reg_addr == ALC_CTRL_OFS);
  assign wr_eif = reg_wr && (reg_addr == ALC_EIF_OFS);
  assign wr_eie = reg_wr && (reg_addr == ALC_EIE_OFS);
  assign srst = wr_ctrl && reg_wdata[ALC_CTRL_SRST_BIT];
  assign ldok_req = wr_ctrl && reg_wdata[ALC_CTRL_LDOK_BIT];
  assign rstar_req = wr_ctrl && reg_wdata[ALC_CTRL_RSTAR_BIT];
  // [R1] any severe flag halts
  assign severe = |(eif_reg & ALC_SEVERE_MASK);
  // [R9] reserved bits or resolution code
  assign cmd_bad = (|(mem_rdata & ALC_CMD_RSVD_MASK)) ||
    ((mem_rdata[ALC_CMD_RES_LO +: 3] != ALC_RES_8) &&
     (mem_rdata[ALC_CMD_RES_LO +: 3] != ALC_RES_10) &&
     (mem_rdata[ALC_CMD_RES_LO +: 3] != ALC_RES_12));
  assign cur_addr = csl_base_reg[csl_sel_reg] + {26'h0, cidx_reg, 2'h0};
  // [R8] fetch outside the legal memory area
  assign addr_bad = (cur_addr < ALC_MEM_LO) || (cur_addr > ALC_MEM_HI);
  // ======================================================================
  // error events gathered per flag
  always_comb begin
    ev_set = 8'h00;
    if (en_reg && !srst) begin
      // [R8] illegal access on fetch or store
      ev_set[ALC_IA_BIT] = (state_reg == ALC_FETCH && !fetch_wait_reg && addr_bad) ||
        (store_wait_reg && mem_err);
      // [R9] bad command loaded
      ev_set[ALC_CMD_BIT] = fetch_wait_reg && cmd_bad;
      // [R10] list ran out without an end marker
      ev_set[ALC_EOL_BIT] = fetch_wait_reg && !cmd_bad && (cidx_reg == ALC_LIST_LEN) &&
        (mem_rdata[ALC_CMD_EOL_LO +: 2] != ALC_EOL_CODE);
      // trigger arriving while a conversion already waits
      ev_set[ALC_TRIG_BIT] = trig_in && trig_pend_reg && !severe;
      // [R3] restart and load requests while busy flag but never halt
      ev_set[ALC_RSTAR_BIT] = rstar_req && (state_reg != ALC_IDLE);
      ev_set[ALC_LDOK_BIT] = ldok_req && (state_reg != ALC_IDLE);
    end
  end
  // ======================================================================
  // error flag register
  always_ff @(posedge clk) begin
    if (rst) begin
      eif_reg <= ALC_EIF_RST;
    end else if (!en_reg) begin
      // [R5] disabled holds all clear
      eif_reg <= ALC_EIF_RST;
    end else if (srst) begin
      // [R2] soft reset clears severe flags
      // [R4] soft reset clears soft flags too
      eif_reg <= ALC_EIF_RST;
    end else begin
      // [R6] ones clear only, set wins over clear
      // [R7] severe bits masked from writes
      eif_reg <= (eif_reg & ~(wr_eif ? (reg_wdata[7:0] & ALC_SOFT_MASK) : 8'h00)) | ev_set;
    end
  end
  // ======================================================================
  // control, mask and list base registers
  always_ff @(posedge clk) begin
    if (rst) begin
      en_reg <= ALC_CTRL_RST[ALC_CTRL_EN_BIT];
      cbm_reg <= ALC_CTRL_RST[ALC_CTRL_CBM_BIT];
      rbm_reg <= ALC_CTRL_RST[ALC_CTRL_RBM_BIT];
      eie_reg <= 8'h00;
      csl_base_reg[0] <= ALC_MEM_LO;
      csl_base_reg[1] <= ALC_MEM_LO;
      rvl_base_reg[0] <= ALC_MEM_LO;
      rvl_base_reg[1] <= ALC_MEM_LO;
    end else begin
      if (wr_ctrl) begin
        en_reg <= reg_wdata[ALC_CTRL_EN_BIT];
        // [R15] independent buffer mode per list
        cbm_reg <= reg_wdata[ALC_CTRL_CBM_BIT];
        rbm_reg <= reg_wdata[ALC_CTRL_RBM_BIT];
      end
      if (wr_eie) begin
        eie_reg <= reg_wdata[7:0] & (ALC_SEVERE_MASK | ALC_SOFT_MASK);
      end
      if (reg_wr && reg_addr == ALC_CSLB0_OFS) csl_base_reg[0] <= reg_wdata;
      if (reg_wr && reg_addr == ALC_CSLB1_OFS) csl_base_reg[1] <= reg_wdata;
      if (reg_wr && reg_addr == ALC_RVLB0_OFS) rvl_base_reg[0] <= reg_wdata;
      if (reg_wr && reg_addr == ALC_RVLB1_OFS) rvl_base_reg[1] <= reg_wdata;
    end
  end
  // ======================================================================
  // trigger latch
  // a pending trigger is dropped on halt so nothing runs after recovery
  always_ff @(posedge clk) begin
    if (rst || !en_reg || srst || severe) begin
      // [R17] triggers ignored while halted
      trig_pend_reg <= 1'b0;
    end else if (trig_in) begin
      trig_pend_reg <= 1'b1;
    end else if (state_reg == ALC_IDLE && trig_pend_reg) begin
      trig_pend_reg <= 1'b0;
    end
  end
  // ======================================================================
  // conversion sequencer
  always_ff @(posedge clk) begin
    mem_rd <= 1'b0;
    mem_wr <= 1'b0;
    sar_start_q <= 1'b0;
    if (rst || !en_reg || srst) begin
      state_reg <= ALC_IDLE;
      fetch_wait_reg <= 1'b0;
      store_wait_reg <= 1'b0;
      cidx_reg <= 4'h0;
      ridx_reg <= 4'h0;
      csl_sel_reg <= 1'b0;
      rvl_sel_reg <= 1'b0;
      pump_cnt_reg <= 2'h0;
      cmd_reg <= ALC_CMD_RST;
      cmd_next_reg <= ALC_CMD_RST;
      mem_addr <= 32'h0;
      mem_wdata <= 32'h0;
      res_reg <= 12'h000;
    end else if (severe || (|ev_set[7:4])) begin
      // [R1] stop everything on severe error
      // [R17] no memory access while halted
      state_reg <= ALC_HALT;
      fetch_wait_reg <= 1'b0;
      store_wait_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        ALC_IDLE: begin
          if (trig_pend_reg) begin
            state_reg <= ALC_FETCH;
          end
        end
        ALC_FETCH: begin
          if (!fetch_wait_reg) begin
            mem_rd <= 1'b1;
            mem_addr <= cur_addr;
            fetch_wait_reg <= 1'b1;
          end else begin
            // [R16] command double buffered
            fetch_wait_reg <= 1'b0;
            cmd_next_reg <= mem_rdata;
            pump_cnt_reg <= 2'(ALC_PUMP_CYC);
            state_reg <= ALC_PUMP;
          end
        end
        ALC_PUMP: begin
          // [R11] two pump cycles first
          if (pump_cnt_reg == 2'h1) begin
            state_reg <= ALC_SAMPLE;
            // [R16] waiting command becomes active
            cmd_reg <= cmd_next_reg;
          end
          pump_cnt_reg <= pump_cnt_reg - 2'h1;
        end
        ALC_SAMPLE: begin
          sar_start_q <= 1'b1;
          state_reg <= ALC_CONV;
        end
        ALC_CONV: begin
          if (sar_done) begin
            res_reg <= sar_code;
            mem_wr <= 1'b1;
            mem_addr <= rvl_base_reg[rvl_sel_reg] + {26'h0, ridx_reg, 2'h0};
            mem_wdata <= {20'h0, sar_code};
            store_wait_reg <= 1'b1;
            state_reg <= ALC_STORE;
          end
        end
        ALC_STORE: begin
          store_wait_reg <= 1'b0;
          ridx_reg <= ridx_reg + 4'h1;
          // [R15] swap buffers at list end when mode is double
          if (cmd_reg[ALC_CMD_EOL_LO +: 2] == ALC_EOL_CODE) begin
            cidx_reg <= 4'h0;
            ridx_reg <= 4'h0;
            if (cbm_reg) csl_sel_reg <= ~csl_sel_reg;
            if (rbm_reg) rvl_sel_reg <= ~rvl_sel_reg;
            state_reg <= ALC_IDLE;
          end else begin
            cidx_reg <= cidx_reg + 4'h1;
            state_reg <= ALC_FETCH;
          end
        end
        ALC_HALT: begin
          state_reg <= ALC_HALT;
        end
        default: begin
          state_reg <= ALC_IDLE;
        end
      endcase
    end
  end
  assign sar_start = sar_start_q;
  // ======================================================================
  // [R12] resolution from the active command
  // [R13] search engine
  alc_sar u_sar (
    .clk(clk),
    .rst(rst),
    .start(sar_start),
    .res_sel(cmd_reg[ALC_CMD_RES_LO +: 3]),
    .sample(sample_in),
    .below_low(below_low_in),
    .above_high(above_high_in),
    .done(sar_done),
    .code(sar_code)
  );
  // ======================================================================
  // phase outputs and interrupt
  always_ff @(posedge clk) begin
    if (rst) begin
      pump_on <= 1'b0;
      sample_on <= 1'b0;
      irq <= 1'b0;
    end else begin
      // a halting event or soft reset keeps the pump from starting
      pump_on <= en_reg && !srst && !(|ev_set[7:4]) &&
        ((state_reg == ALC_FETCH && fetch_wait_reg) ||
        (state_reg == ALC_PUMP && pump_cnt_reg != 2'h1));
      sample_on <= (state_reg == ALC_PUMP) && (pump_cnt_reg == 2'h1);
      irq <= |(eif_reg & eie_reg);
    end
  end
  // ======================================================================
  // read port, unmapped reads return zero
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        ALC_CTRL_OFS: reg_rdata <= {28'h0, rbm_reg, cbm_reg, 1'b0, en_reg};
        ALC_STAT_OFS: reg_rdata <= {24'h0, state_reg == ALC_HALT, state_reg != ALC_IDLE,
                                    2'h0, 2'h0, rvl_sel_reg, csl_sel_reg};
        ALC_EIF_OFS: reg_rdata <= {24'h0, eif_reg};
        ALC_EIE_OFS: reg_rdata <= {24'h0, eie_reg};
        ALC_CSLB0_OFS: reg_rdata <= csl_base_reg[0];
        ALC_CSLB1_OFS: reg_rdata <= csl_base_reg[1];
        ALC_RVLB0_OFS: reg_rdata <= rvl_base_reg[0];
        ALC_RVLB1_OFS: reg_rdata <= rvl_base_reg[1];
        // [R16] active command readable
        ALC_CMD_OFS: reg_rdata <= cmd_reg;
        ALC_RES_OFS: reg_rdata <= {20'h0, res_reg};
        default: reg_rdata <= 32'h0;
      endcase
    end else begin
      reg_rdata <= 32'h0;
    end
  end
endmodule

// File: rtl/alc_pkg.sv
// package of constants and types for the list-based converter control block
package alc_pkg;
  // ======================================================================
  // register map (byte offsets on the plain register port)
  localparam logic [7:0] ALC_CTRL_OFS = 8'h00; // enable, soft reset, buffer modes, load and restart requests
  localparam logic [7:0] ALC_STAT_OFS = 8'h04; // halted, busy, buffer selections
  localparam logic [7:0] ALC_EIF_OFS = 8'h08; // converter_error_flags
  localparam logic [7:0] ALC_EIE_OFS = 8'h0c; // error interrupt mask
  localparam logic [7:0] ALC_CSLB0_OFS = 8'h10; // command list base, buffer 0
  localparam logic [7:0] ALC_CSLB1_OFS = 8'h14; // command list base, buffer 1
  localparam logic [7:0] ALC_RVLB0_OFS = 8'h18; // result list base, buffer 0
  localparam logic [7:0] ALC_RVLB1_OFS = 8'h1c; // result list base, buffer 1
  localparam logic [7:0] ALC_CMD_OFS = 8'h20; // active_command_view
  localparam logic [7:0] ALC_RES_OFS = 8'h24; // last result
  // ======================================================================
  // control register fields
  localparam int ALC_CTRL_EN_BIT = 0;
  localparam int ALC_CTRL_SRST_BIT = 1;
  localparam int ALC_CTRL_CBM_BIT = 2;
  localparam int ALC_CTRL_RBM_BIT = 3;
  localparam int ALC_CTRL_LDOK_BIT = 4;
  localparam int ALC_CTRL_RSTAR_BIT = 5;
  localparam logic [7:0] ALC_CTRL_RST = 8'h00;
  // ======================================================================
  // error flag positions
  localparam int ALC_IA_BIT = 7;
  localparam int ALC_CMD_BIT = 6;
  localparam int ALC_EOL_BIT = 5;
  localparam int ALC_TRIG_BIT = 4;
  localparam int ALC_RSTAR_BIT = 3;
  localparam int ALC_LDOK_BIT = 2;
  localparam logic [7:0] ALC_EIF_RST = 8'h00;
  localparam logic [7:0] ALC_SEVERE_MASK = 8'hf0;
  localparam logic [7:0] ALC_SOFT_MASK = 8'h0c;
  // ======================================================================
  // command word layout
  localparam int ALC_CMD_EOL_LO = 30; // [31:30] list end type, 2'b01 = end of list
  localparam int ALC_CMD_RES_LO = 24; // [26:24] result_resolution_select
  localparam logic [1:0] ALC_EOL_CODE = 2'h1;
  localparam logic [2:0] ALC_RES_8 = 3'h2;
  localparam logic [2:0] ALC_RES_10 = 3'h3;
  localparam logic [2:0] ALC_RES_12 = 3'h4;
  localparam logic [31:0] ALC_CMD_RSVD_MASK = 32'h38ff0000; // reserved command bits
  // ======================================================================
  // memory window and timing
  localparam logic [31:0] ALC_MEM_LO = 32'h00001000; // start of legal list area
  localparam logic [31:0] ALC_MEM_HI = 32'h000fffff; // end of legal list area
  localparam int ALC_PUMP_CYC = 2;
  localparam logic [3:0] ALC_LIST_LEN = 4'hf; // entries before missing list end
  localparam logic [31:0] ALC_CMD_RST = 32'h00000000;
  // ======================================================================
  // conversion sequencer states, gray from idle through store
  typedef enum logic [2:0] {
    ALC_IDLE = 3'b000,
    ALC_FETCH = 3'b001,
    ALC_PUMP = 3'b011,
    ALC_SAMPLE = 3'b010,
    ALC_CONV = 3'b110,
    ALC_STORE = 3'b111,
    ALC_HALT = 3'b101
  } alc_state_t;
endpackage

// File: rtl/alc_sar.sv
// successive approximation engine with clamping to the reference span
module alc_sar
  import alc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic start, // one-cycle start, held sample is valid
  input wire logic [2:0] res_sel, // resolution code
  input wire logic [11:0] sample, // held input, scaled to 12 bits
  input wire logic below_low, // input beneath low reference
  input wire logic above_high, // input above high reference
  output logic done, // one-cycle completion
  output logic [11:0] code // result, right aligned
);
  // ======================================================================
  // search state
  logic [11:0] trial_reg; // bits decided so far
  logic [11:0] bit_reg; // weight under test
  logic run_reg; // search in progress
  logic [11:0] top_bit; // first weight, the same for every resolution
  logic [3:0] shift; // right alignment shift
  logic [11:0] cand; // trial with current weight added
  always_comb begin
    top_bit = 12'h800;
    shift = 4'h0;
    if (res_sel == ALC_RES_8) begin
      shift = 4'h4;
    end else if (res_sel == ALC_RES_10) begin
      shift = 4'h2;
    end
    cand = trial_reg | bit_reg;
  end
  // ======================================================================
  // [R13] binary search step
  // one weight decided per clock, lower resolutions stop early
  always_ff @(posedge clk) begin
    done <= 1'b0;
    if (rst) begin
      trial_reg <= 12'h000;
      bit_reg <= 12'h000;
      run_reg <= 1'b0;
      code <= 12'h000;
    end else if (start) begin
      trial_reg <= 12'h000;
      bit_reg <= top_bit;
      run_reg <= 1'b1;
    end else if (run_reg) begin
      // keep weight when the level stays at or below the sample
      if (cand <= sample) begin
        trial_reg <= cand;
      end
      bit_reg <= bit_reg >> 1;
      if ((bit_reg >> shift) == 12'h001) begin
        run_reg <= 1'b0;
        done <= 1'b1;
        // [R14] railed code outside span
        if (below_low) begin
          code <= 12'h000;
        end else if (above_high) begin
          code <= 12'hfff >> shift;
        end else begin
          code <= ((cand <= sample) ? cand : trial_reg) >> shift;
        end
      end
    end
  end
endmodule

// File: testbench/alc_top_props.sv
// concurrent checks on the converter control block ports
module alc_top_props
  import alc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [31:0] mem_wdata,
  input wire logic pump_on,
  input wire logic sample_on,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic en_q; // enable bit as last written
  logic [7:0] mask_q; // error mask as last written
  logic [1:0] off_cnt; // cycles spent disabled, saturating
  logic [1:0] quiet_cnt; // cycles with the interrupt path shut
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ======================================================================
  // shadow of the writes that shut the interrupt path
  always_ff @(posedge clk) begin
    if (rst) begin
      en_q <= 1'b0;
      mask_q <= 8'h00;
    end else if (reg_wr && reg_addr == ALC_CTRL_OFS) begin
      en_q <= reg_wdata[ALC_CTRL_EN_BIT];
    end else if (reg_wr && reg_addr == ALC_EIE_OFS) begin
      mask_q <= reg_wdata[7:0];
    end
  end
  // counters give the flags and the registered irq time to settle
  always_ff @(posedge clk) begin
    if (rst || en_q) begin
      off_cnt <= 2'h0;
    end else if (off_cnt != 2'h3) begin
      off_cnt <= off_cnt + 2'h1;
    end
    if (rst || (en_q && mask_q != 8'h00)) begin
      quiet_cnt <= 2'h0;
    end else if (quiet_cnt != 2'h3) begin
      quiet_cnt <= quiet_cnt + 2'h1;
    end
  end
  // ======================================================================
  // pump phase is exactly two cycles, then sampling
  sequence pump_run;
    pump_on ##1 (pump_on && !sample_on) ##1 (!pump_on && sample_on);
  endsequence
  sequence cmd_loaded;
    $past(mem_rd) || $past(mem_rd, 2);
  endsequence
  pump_two_a: assert property ($rose(pump_on) |-> pump_run)
    else $error("pump phase length wrong");
  pump_fetch_a: assert property ($rose(pump_on) |-> cmd_loaded)
    else $error("pump started without a command fetch");
  pump_quiet_a: assert property (pump_on |-> !mem_rd && !mem_wr)
    else $error("memory access during pump phase");
  store_align_a: assert property (mem_wr |-> mem_wdata[31:12] == 20'h0)
    else $error("stored result wider than twelve bits");
  off_read_a: assert property ((off_cnt == 2'h3 && reg_rd && reg_addr == ALC_EIF_OFS)
    |=> reg_rdata == 32'h0)
    else $error("error flags not clear while disabled");
  irq_quiet_a: assert property (quiet_cnt == 2'h3 |-> !irq)
    else $error("interrupt with disabled block or empty mask");
  read_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside read cycle");
  fetch_pulse_a: assert property (mem_rd |=> !mem_rd)
    else $error("fetch request longer than one cycle");
endmodule
bind alc_top alc_top_props u_props (.clk(clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .pump_on(pump_on),
  .sample_on(sample_on), .irq(irq));

// File: testbench/alc_mem_model.sv
// system memory holding the command list and catching stored results
module alc_mem_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic store_fault, // bench asks for a failing store
  output logic [31:0] mem_rdata,
  output logic mem_err
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] cmds [16]; // command words, by word address
  logic [31:0] last_store; // latest stored result
  int reads = 0; // fetches seen
  int stores = 0; // stores seen
  // ======================================================================
  logic [31:0] fill; // toggling filler between fetches
  // the block takes command and error in the cycle of its request; the
  // filler toggles so that a late sample never sees a stale command
  assign mem_rdata = mem_rd ? cmds[mem_addr[5:2]] : fill;
  assign mem_err = mem_wr && store_fault;
  always_ff @(posedge clk) begin
    fill <= rst ? 32'h5a5a5a5a : ~fill;
    if (mem_rd) begin
      reads <= reads + 1;
    end
    if (mem_wr) begin
      stores <= stores + 1;
      last_store <= mem_wdata;
    end
  end
endmodule

// File: testbench/alc_top_tb_top.sv
// self-checking bench for the list-based converter control block
module alc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import alc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic trig_in = 1'b0;
  logic [11:0] sample_in = 12'h000;
  logic below_low_in = 1'b0;
  logic above_high_in = 1'b0;
  logic store_fault = 1'b0;
  logic [31:0] reg_rdata, mem_addr, mem_wdata, mem_rdata;
  logic mem_rd, mem_wr, mem_err, pump_on, sample_on, irq;
  int fails = 0;
  int samples_checked = 0;
  alc_top DUT (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trig_in(trig_in),
    .sample_in(sample_in), .below_low_in(below_low_in), .above_high_in(above_high_in),
    .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .mem_err(mem_err), .pump_on(pump_on), .sample_on(sample_on),
    .irq(irq));
  alc_mem_model MEM (.clk(clk), .rst(rst), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .store_fault(store_fault),
    .mem_rdata(mem_rdata), .mem_err(mem_err));
  // ======================================================================
  // 25 MHz clock
  initial begin
    forever #20 clk = ~clk;
  end
  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    if (fails == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // one-cycle register write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // one-cycle read, data judged in the following cycle
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  task automatic trig(input int len, input logic [11:0] s, input logic bl, input logic ah);
    @(posedge clk);
    sample_in <= s;
    below_low_in <= bl;
    above_high_in <= ah;
    trig_in <= 1'b1;
    repeat (len) @(posedge clk);
    trig_in <= 1'b0;
  endtask
  // bounded wait for a new store or for the interrupt
  task automatic wait_ev(input int lim, input bit on_irq, input int n);
    int k;
    k = 0;
    while (k < lim && (on_irq ? irq !== 1'b1 : MEM.stores == n)) begin
      @(posedge clk);
      k++;
    end
    chk({31'h0, k < lim}, 32'h1);
  endtask
  // ======================================================================
  // soft flags: set while busy, no halt, write-one clear, soft reset
  task automatic t_soft();
    int n;
    MEM.cmds[0] = 32'h44000000;
    n = MEM.stores;
    trig(1, 12'h0ff, 1'b0, 1'b0);
    wr(ALC_CTRL_OFS, 32'h31);
    wait_ev(200, 1'b0, n);
    rd_chk(ALC_EIF_OFS, 32'h0c);
    wr(ALC_EIF_OFS, 32'h0);
    rd_chk(ALC_EIF_OFS, 32'h0c);
    wr(ALC_EIE_OFS, 32'h04);
    rd_chk(ALC_EIE_OFS, 32'h04);
    chk({31'h0, irq}, 32'h1);
    wr(ALC_EIE_OFS, 32'h0);
    rd_chk(ALC_EIF_OFS, 32'h0c);
    chk({31'h0, irq}, 32'h0);
    wr(ALC_EIF_OFS, 32'h04);
    rd_chk(ALC_EIF_OFS, 32'h08);
    wr(ALC_CTRL_OFS, 32'h3);
    rd_chk(ALC_EIF_OFS, 32'h0);
    wr(ALC_EIF_OFS, 32'h0c);
    rd_chk(ALC_EIF_OFS, 32'h0);
  endtask
  // severe error: flag, halt, writes ignored, then soft reset or disable
  task automatic t_severe(input logic [31:0] cmd, input bit all, input logic [31:0] base,
      input logic fault, input int tlen, input bit off, input logic [31:0] exp);
    int r;
    wr(ALC_EIE_OFS, 32'hf0);
    wr(ALC_CSLB0_OFS, base);
    for (int i = 0; i < 16; i++) begin
      if (all || i == 0) MEM.cmds[i] = cmd;
    end
    store_fault <= fault;
    trig(tlen, 12'h123, 1'b0, 1'b0);
    wait_ev(1000, 1'b1, 0);
    rd_chk(ALC_EIF_OFS, exp);
    r = MEM.reads;
    trig(1, 12'h123, 1'b0, 1'b0);
    repeat (20) @(posedge clk);
    chk(32'(MEM.reads - r), 32'h0);
    wr(ALC_EIF_OFS, 32'hff);
    rd_chk(ALC_EIF_OFS, exp);
    wr(ALC_CTRL_OFS, off ? 32'h0 : 32'h3);
    rd_chk(ALC_EIF_OFS, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(ALC_CTRL_OFS, 32'h1);
    store_fault <= 1'b0;
    wr(ALC_CSLB0_OFS, 32'h2000);
  endtask
  // every resolution with in-span, under and over inputs
  task automatic t_res();
    logic [2:0] codes [3];
    logic [31:0] cmd, exp;
    int w, n;
    codes = '{ALC_RES_8, ALC_RES_10, ALC_RES_12};
    for (int r = 0; r < 3; r++) begin
      for (int c = 0; c < 3; c++) begin
        w = 8 + 2 * r;
        cmd = {2'b01, 3'b000, codes[r], 24'h0};
        MEM.cmds[0] = cmd;
        exp = (c == 0) ? 32'(12'h9a5 >> (12 - w)) : (c == 1) ? 32'h0 : (32'h1 << w) - 1;
        n = MEM.stores;
        trig(1, 12'h9a5, c == 1, c == 2);
        wait_ev(200, 1'b0, n);
        chk(MEM.last_store, exp);
        rd_chk(ALC_RES_OFS, exp);
        rd_chk(ALC_CMD_OFS, cmd);
      end
    end
  endtask
  // ======================================================================
  // main sequence
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    rd_chk(ALC_EIF_OFS, 32'h0);
    rd_chk(ALC_CTRL_OFS, 32'h0);
    rd_chk(8'hfc, 32'h0);
    wr(ALC_CSLB0_OFS, 32'h2000);
    wr(ALC_RVLB0_OFS, 32'h3000);
    wr(ALC_CTRL_OFS, 32'h1);
    t_soft();
    t_severe(32'h48000000, 1'b0, 32'h2000, 1'b0, 1, 1'b0, 32'h40);
    t_severe(32'h47000000, 1'b0, 32'h2000, 1'b0, 1, 1'b0, 32'h40);
    t_severe(32'h44000000, 1'b0, 32'h800, 1'b0, 1, 1'b0, 32'h80);
    t_severe(32'h44000000, 1'b0, 32'h2000, 1'b1, 1, 1'b0, 32'h80);
    t_severe(32'h04000000, 1'b1, 32'h2000, 1'b0, 1, 1'b0, 32'h20);
    t_severe(32'h44000000, 1'b0, 32'h2000, 1'b0, 2, 1'b1, 32'h10);
    t_res();
    end_of_test();
  end
  // hang guard, well beyond the expected thousand or so cycles
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    end_of_test();
  end
endmodule
